// File: logic/lcdr_ram_addr.v
// Display memory, byte packing, pointer, subaddress and row sequencing
`timescale 1ns/10ps
`include "lcdr_map.vh"
module lcdr_ram_addr #(
  parameter PHASE_CYCLES = `LCDR_PHASE_CYCLES
) (
  input wire clock,              // frame clock, 125 MHz
  input wire rstn,               // async reset, active low
  input wire link_clk,           // byte strobe clock from bus side
  input wire link_valid,         // byte present on link
  input wire link_cmd,           // 1 command byte, 0 display data
  input wire [7:0] link_data,    // byte value
  output reg link_ready,         // room for a byte
  input wire hw_subaddr_pin_0,   // hardware subaddress bit 0
  input wire hw_subaddr_pin_1,   // hardware subaddress bit 1
  input wire hw_subaddr_pin_2,   // hardware subaddress bit 2
  output reg byte_done,          // pulse, byte processed
  output reg byte_ack,           // with byte_done: byte acknowledged
  output reg backplane_out_0,    // backplane 0 drive
  output reg backplane_out_1,    // backplane 1 drive
  output reg backplane_out_2,    // backplane 2 drive
  output reg backplane_out_3,    // backplane 3 drive
  output reg [79:0] segment_out, // segment drives, bit 0 first
  output reg [1:0] mode_out,     // current drive mode
  output reg [6:0] pointer_out,  // current data pointer
  output reg [2:0] subaddr_out   // current subaddress counter
);
  // -------------------------------------------------------------
  // Input synchronisation and byte capture
  // -------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_WORD = 2'h1;
  localparam ST_ACK = 2'h2;

  wire [10:0] link_s;
  wire [2:0] hw_sub_s;
  reg link_clk_d_reg;
  wire cap;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [8:0] fifo_out_data;

  lcdr_sync #(.W(11)) u_link_sync (
    .clock(clock),
    .rstn(rstn),
    .d({link_clk, link_valid, link_cmd, link_data}),
    .q(link_s)
  );

  lcdr_sync #(.W(3)) u_sub_sync (
    .clock(clock),
    .rstn(rstn),
    .d({hw_subaddr_pin_2, hw_subaddr_pin_1, hw_subaddr_pin_0}),
    .q(hw_sub_s)
  );

  // All link bits share the same sync delay, so data is stable at the edge
  assign cap = link_s[10] & ~link_clk_d_reg & link_s[9];

  lcdr_fifo2 #(.W(9)) u_buf (
    .clock(clock),
    .rstn(rstn),
    .in_valid(cap),
    .in_ready(fifo_in_ready),
    .in_data(link_s[8:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  reg [3:0] mem_reg [0:`LCDR_COLS-1];
  reg [1:0] state_reg;
  reg [1:0] mode_reg;
  reg [6:0] ptr_reg;
  reg [2:0] sub_reg;
  reg ibank_reg;
  reg obank_reg;
  reg [7:0] sh_reg;
  reg [3:0] words_reg;
  reg stored_reg;
  reg ack_pend_reg;
  reg [15:0] ph_cnt_reg;
  reg [1:0] phase_reg;
  reg inv_reg;
  reg [3:0] wdata;
  reg [3:0] wmask;
  reg [2:0] bits_per_word;
  reg [3:0] words_per_byte;
  reg [1:0] row_sel;
  reg [1:0] last_phase;
  reg [79:0] row_bits;
  reg [3:0] bp_next;
  wire match;
  wire [7:0] cmd;
  wire phase_end;
  integer i, j;

  assign fifo_out_ready = (state_reg == ST_IDLE);
  assign cmd = fifo_out_data[7:0];
  assign match = (sub_reg == hw_sub_s);
  assign phase_end = (ph_cnt_reg == PHASE_CYCLES - 1);

  // -------------------------------------------------------------
  // Packing of one column word
  // -------------------------------------------------------------
  always @*
  begin
    wdata = 4'h0;
    wmask = 4'h0;
    bits_per_word = 3'h4;
    words_per_byte = 4'h2;
    case (mode_reg)
      `LCDR_MODE_STATIC:
      begin
        bits_per_word = 3'h1;
        words_per_byte = 4'h8;
        if (ibank_reg)
        begin
          wdata[2] = sh_reg[7];
          wmask = 4'h4;
        end
        else
        begin
          wdata[0] = sh_reg[7];
          wmask = 4'h1;
        end
      end
      `LCDR_MODE_TWO:
      begin
        bits_per_word = 3'h2;
        words_per_byte = 4'h4;
        if (ibank_reg)
        begin
          wdata = {sh_reg[6], sh_reg[7], 2'h0};
          wmask = 4'hC;
        end
        else
        begin
          wdata = {2'h0, sh_reg[6], sh_reg[7]};
          wmask = 4'h3;
        end
      end
      `LCDR_MODE_THREE:
      begin
        bits_per_word = 3'h3;
        words_per_byte = 4'h3;
        wdata = {1'b0, sh_reg[5], sh_reg[6], sh_reg[7]};
        wmask = (words_reg == 4'h1) ? 4'h3 : 4'h7;
      end
      default:
      begin
        bits_per_word = 3'h4;
        words_per_byte = 4'h2;
        wdata = {sh_reg[4], sh_reg[5], sh_reg[6], sh_reg[7]};
        wmask = 4'hF;
      end
    endcase
  end

  // -------------------------------------------------------------
  // Command decode and byte writer
  // -------------------------------------------------------------
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (i = 0; i < `LCDR_COLS; i = i + 1)
      begin
        mem_reg[i] <= 4'h0;
      end
      state_reg <= ST_IDLE;
      mode_reg <= `LCDR_MODE_RST;
      ptr_reg <= 7'h00;
      sub_reg <= 3'h0;
      ibank_reg <= 1'b0;
      obank_reg <= 1'b0;
      sh_reg <= 8'h00;
      words_reg <= 4'h0;
      stored_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      byte_done <= 1'b0;
      byte_ack <= 1'b0;
      link_clk_d_reg <= 1'b0;
      link_ready <= 1'b0;
    end
    else
    begin
      link_clk_d_reg <= link_s[10];
      // Ready only when empty, so a byte already in the sync path still fits
      link_ready <= ~fifo_out_valid & fifo_in_ready;
      byte_done <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (fifo_out_valid)
          begin
            if (fifo_out_data[8])
            begin
              ack_pend_reg <= 1'b1;
              state_reg <= ST_ACK;
              if (!cmd[7])
              begin
                ptr_reg <= cmd[6:0];
              end
              else if (cmd[7:3] == `LCDR_OP_CHIP)
              begin
                sub_reg <= cmd[2:0];
              end
              else if (cmd[7:2] == `LCDR_OP_BANK)
              begin
                if (mode_reg == `LCDR_MODE_STATIC || mode_reg == `LCDR_MODE_TWO)
                begin
                  ibank_reg <= cmd[1];
                  obank_reg <= cmd[0];
                end
              end
              else if (cmd[7:4] == `LCDR_OP_MODE)
              begin
                mode_reg <= cmd[1:0];
              end
            end
            else
            begin
              sh_reg <= cmd;
              words_reg <= words_per_byte;
              stored_reg <= 1'b0;
              state_reg <= ST_WORD;
            end
          end
        end
        ST_WORD:
        begin
          if (match)
          begin
            // Whole column in one edge, display reads never see half a word
            mem_reg[ptr_reg] <= (mem_reg[ptr_reg] & ~wmask) | (wdata & wmask);
            stored_reg <= 1'b1;
          end
          if (ptr_reg >= `LCDR_LAST_COL)
          begin
            ptr_reg <= 7'h00;
            sub_reg <= sub_reg + 3'h1;
          end
          else
          begin
            ptr_reg <= ptr_reg + 7'h01;
          end
          sh_reg <= sh_reg << bits_per_word;
          words_reg <= words_reg - 4'h1;
          if (words_reg == 4'h1)
          begin
            ack_pend_reg <= stored_reg | match;
            state_reg <= ST_ACK;
          end
        end
        ST_ACK:
        begin
          byte_done <= 1'b1;
          byte_ack <= ack_pend_reg;
          state_reg <= ST_IDLE;
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // Row sequencer and output drive
  // -------------------------------------------------------------
  always @*
  begin
    case (mode_reg)
      `LCDR_MODE_STATIC: last_phase = 2'h0;
      `LCDR_MODE_TWO: last_phase = 2'h1;
      `LCDR_MODE_THREE: last_phase = 2'h2;
      default: last_phase = 2'h3;
    endcase
    row_sel = phase_reg;
    if ((mode_reg == `LCDR_MODE_STATIC || mode_reg == `LCDR_MODE_TWO) && obank_reg)
    begin
      row_sel = phase_reg + 2'h2;
    end
    for (j = 0; j < `LCDR_COLS; j = j + 1)
    begin
      row_bits[j] = mem_reg[j][row_sel];
    end
    bp_next = 4'h0;
    bp_next[phase_reg] = 1'b1;
    case (mode_reg)
      `LCDR_MODE_STATIC: bp_next = {4{bp_next[0]}};
      `LCDR_MODE_TWO: bp_next = {bp_next[1:0], bp_next[1:0]};
      `LCDR_MODE_THREE: bp_next = {bp_next[1], bp_next[2:0]};
      default: bp_next = bp_next;
    endcase
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ph_cnt_reg <= 16'h0000;
      phase_reg <= 2'h0;
      inv_reg <= 1'b0;
      backplane_out_0 <= 1'b0;
      backplane_out_1 <= 1'b0;
      backplane_out_2 <= 1'b0;
      backplane_out_3 <= 1'b0;
      segment_out <= 80'h0;
      mode_out <= `LCDR_MODE_RST;
      pointer_out <= 7'h00;
      subaddr_out <= 3'h0;
    end
    else
    begin
      mode_out <= mode_reg;
      pointer_out <= ptr_reg;
      subaddr_out <= sub_reg;
      if (phase_end)
      begin
        ph_cnt_reg <= 16'h0000;
        if (phase_reg >= last_phase)
        begin
          phase_reg <= 2'h0;
          // Polarity flips each frame to keep the cells free of DC
          inv_reg <= ~inv_reg;
        end
        else
        begin
          phase_reg <= phase_reg + 2'h1;
        end
      end
      else
      begin
        ph_cnt_reg <= ph_cnt_reg + 16'h0001;
      end
      backplane_out_0 <= bp_next[0] ^ inv_reg;
      backplane_out_1 <= bp_next[1] ^ inv_reg;
      backplane_out_2 <= bp_next[2] ^ inv_reg;
      backplane_out_3 <= bp_next[3] ^ inv_reg;
      segment_out <= row_bits ^ {80{inv_reg}};
    end
  end
endmodule

// File: logic/lcdr_map.vh
// Constants for the display memory and addressing block
// Contract
// - Three-backplane mode: output 3 copies output 1
// - Two-backplane mode: outputs 2,3 copy 0,1
// - Static mode: all four backplanes identical
// - Memory 80 columns by 4 rows, 1 on
// - Static: byte goes to row 0, eight columns
// - Two-backplane: four 2-bit words, MSB first
// - Three-backplane: three 3-bit words, last bit untouched
// - Three-backplane: new byte overwrites rows 0-2
// - Four-backplane: two 4-bit words, rows 0-3
// - Pointer-load sets start column of next byte
// - Pointer steps 8, 4, 3, 2 by mode
// - Store only when subaddress counter matches pins
// - Mismatch: no store, pointer still advances
// - Pointer overflow increments subaddress counter
// - Next cascaded device stores and acknowledges overflow
// - Last device discards overflow, no acknowledge
// - Row sequence follows drive mode
// - Output bank shows rows 2,3 instead
// - Input bank stores rows 2,3 instead
// - Input and output bank held separately
// - Pointer-load: bit 7 clear, low seven bits
// - Chip-choose 11100 loads subaddress counter
// - Bank-choose 111110, ignored in 3/4 modes
// - Drive field 01,10,11,00 sets mode
`ifndef LCDR_MAP_VH
`define LCDR_MAP_VH

`define LCDR_COLS 80
`define LCDR_LAST_COL 7'h4F
`define LCDR_MODE_FOUR 2'h0
`define LCDR_MODE_STATIC 2'h1
`define LCDR_MODE_TWO 2'h2
`define LCDR_MODE_THREE 2'h3
`define LCDR_MODE_RST 2'h0
`define LCDR_OP_MODE 4'hC
`define LCDR_OP_CHIP 5'h1C
`define LCDR_OP_BANK 6'h3E
`define LCDR_PHASE_CYCLES 6

`endif

// File: logic/lcdr_sync.v
// Two-stage synchroniser for signals from outside the clock domain
`timescale 1ns/10ps
module lcdr_sync #(
  parameter W = 1
) (
  input wire clock,        // frame clock
  input wire rstn,         // async reset, active low
  input wire [W-1:0] d,    // asynchronous input
  output reg [W-1:0] q     // synchronised output
);
  reg [W-1:0] meta_reg;

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// File: logic/lcdr_fifo2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module lcdr_fifo2 #(
  parameter W = 9
) (
  input wire clock,          // frame clock
  input wire rstn,           // async reset, active low
  input wire in_valid,       // write request
  output wire in_ready,      // space available
  input wire [W-1:0] in_data,   // write data
  output wire out_valid,     // data available
  input wire out_ready,      // reader takes data
  output wire [W-1:0] out_data  // oldest entry
);
  reg [W-1:0] ent0_reg;
  reg [W-1:0] ent1_reg;
  reg [1:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = ent0_reg;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ent0_reg <= {W{1'b0}};
      ent1_reg <= {W{1'b0}};
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (pop)
      begin
        ent0_reg <= (push && cnt_reg == 2'h1) ? in_data : ent1_reg;
      end
      else if (push && cnt_reg == 2'h0)
      begin
        ent0_reg <= in_data;
      end
      if (push && ((cnt_reg == 2'h1 && !pop) || (cnt_reg == 2'h2)))
      begin
        ent1_reg <= in_data;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: bench/lcdr_host.sv
// Host side model presenting bytes on the link
`timescale 1ns/10ps
module lcdr_host (
  input wire clock,          // pacing clock
  input wire link_ready,     // room in device buffer
  output reg link_clk,       // byte strobe
  output reg link_valid,     // byte present
  output reg link_cmd,       // command flag
  output reg [7:0] link_data // byte value
);
  initial
  begin
    link_clk = 1'b0;
    link_valid = 1'b0;
    link_cmd = 1'b0;
    link_data = 8'h00;
  end

  // Strobe idles low between bytes; released lines show the inverse of the last value
  task send(input c, input [7:0] d);
    integer t;
    begin
      t = 0;
      @(posedge clock);
      while (!link_ready && t < 400)
      begin
        @(posedge clock);
        t = t + 1;
      end
      link_valid <= 1'b1;
      link_cmd <= c;
      link_data <= d;
      repeat (5) @(posedge clock);
      link_clk <= 1'b1;
      repeat (5) @(posedge clock);
      link_clk <= 1'b0;
      repeat (5) @(posedge clock);
      link_valid <= 1'b0;
      link_cmd <= ~c;
      link_data <= ~d;
    end
  endtask
endmodule

// File: bench/lcdr_ram_addr_props.sv
// Assertions on the display memory block ports
`timescale 1ns/10ps
module lcdr_ram_addr_props (
  input wire clock,           // frame clock
  input wire rstn,            // async reset, active low
  input wire byte_done,       // byte processed
  input wire byte_ack,        // byte acknowledged
  input wire backplane_out_0, // backplane 0
  input wire backplane_out_1, // backplane 1
  input wire backplane_out_2, // backplane 2
  input wire backplane_out_3, // backplane 3
  input wire [1:0] mode_out,  // drive mode
  input wire [6:0] pointer_out, // data pointer
  input wire [2:0] subaddr_out  // subaddress counter
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire [3:0] bp = {backplane_out_3, backplane_out_2, backplane_out_1, backplane_out_0};

  a_static_same: assert property ((mode_out == 2'h1) [*4] |-> (bp == 4'h0 || bp == 4'hF))
    else $error("static backplanes differ");
  a_two_pairs: assert property ((mode_out == 2'h2) [*4] |-> (bp[2] == bp[0] && bp[3] == bp[1]))
    else $error("two-backplane pairs differ");
  a_three_copy: assert property ((mode_out == 2'h3) [*4] |-> bp[3] == bp[1])
    else $error("three-backplane copy differs");
  a_four_phase: assert property ((mode_out == 2'h0) [*4] |-> ($onehot(bp) || $onehot(~bp)))
    else $error("four-backplane phase not single");
  a_ack_hold: assert property (!byte_done |-> $stable(byte_ack))
    else $error("ack moved without byte end");
  a_wrap_sub: assert property ($past(pointer_out) == 7'h4F && pointer_out == 7'h00 |->
    subaddr_out == $past(subaddr_out) + 3'h1)
    else $error("wrap without subaddress step");
  a_mode_cause: assert property ($changed(mode_out) |-> ##[0:4] byte_done)
    else $error("mode moved without command");
  a_sub_cause: assert property ($changed(subaddr_out) |-> ##[0:12] byte_done)
    else $error("subaddress moved without byte");
  a_ptr_cause: assert property ($changed(pointer_out) |-> ##[0:12] byte_done)
    else $error("pointer moved without byte");
endmodule

bind lcdr_ram_addr lcdr_ram_addr_props lcdr_ram_addr_props_i (.clock(clock), .rstn(rstn),
  .byte_done(byte_done), .byte_ack(byte_ack), .backplane_out_0(backplane_out_0),
  .backplane_out_1(backplane_out_1), .backplane_out_2(backplane_out_2),
  .backplane_out_3(backplane_out_3), .mode_out(mode_out), .pointer_out(pointer_out),
  .subaddr_out(subaddr_out));

// File: bench/lcdr_ram_addr_bench.sv
// Self-checking bench for the display memory addressing block
`timescale 1ns/10ps
`include "lcdr_map.vh"
module lcdr_ram_addr_bench;
  reg clock = 1'b0;
  reg rstn = 1'b0;
  reg [2:0] pins = 3'h0;
  wire link_clk, link_valid, link_cmd, link_ready, byte_done, byte_ack;
  wire [7:0] link_data;
  wire [3:0] bp;
  wire [79:0] seg;
  wire [1:0] mode;
  wire [6:0] ptr;
  wire [2:0] sub;
  integer n_mismatch = 0, n_tests = 0, n_done = 0, n_sent = 0, cyc = 0, i;
  reg [31:0] rs = 32'hEE3ABEF2;
  reg [7:0] b, b2, b3;
  reg [6:0] p;
  reg [2:0] q;
  reg [79:0] r;

  always #4 clock = ~clock;

  lcdr_ram_addr lcdr_ram_addr_i (.clock(clock), .rstn(rstn), .link_clk(link_clk),
    .link_valid(link_valid), .link_cmd(link_cmd), .link_data(link_data), .link_ready(link_ready),
    .hw_subaddr_pin_0(pins[0]), .hw_subaddr_pin_1(pins[1]), .hw_subaddr_pin_2(pins[2]),
    .byte_done(byte_done), .byte_ack(byte_ack), .backplane_out_0(bp[0]), .backplane_out_1(bp[1]),
    .backplane_out_2(bp[2]), .backplane_out_3(bp[3]), .segment_out(seg), .mode_out(mode),
    .pointer_out(ptr), .subaddr_out(sub));
  lcdr_host lcdr_host_i (.clock(clock), .link_ready(link_ready), .link_clk(link_clk),
    .link_valid(link_valid), .link_cmd(link_cmd), .link_data(link_data));

  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction

  function [6:0] step(input [1:0] m);
    step = m == `LCDR_MODE_STATIC ? 7'h08 : m == `LCDR_MODE_TWO ? 7'h04 : m == `LCDR_MODE_THREE ? 7'h03 : 7'h02;
  endfunction

  function [7:0] rev(input [7:0] x);
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1)
        rev[k] = x[7 - k];
    end
  endfunction

  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task chk(input [79:0] g, input [79:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask

  // w=0 leaves the byte queued so the next one follows back to back
  task put(input c, input [7:0] d, input w);
    integer t;
    begin
      n_sent = n_sent + 1;
      lcdr_host_i.send(c, d);
      t = 0;
      while (w && n_done < n_sent && t < 400)
      begin
        @(posedge clock);
        t = t + 1;
      end
      if (t == 400)
        n_mismatch = n_mismatch + 1;
      @(posedge clock);
    end
  endtask

  // Static row seen on the segments, frame polarity removed
  task look;
    begin
      repeat (16) @(posedge clock);
      @(negedge clock);
      r = seg ^ {80{~bp[0]}};
    end
  endtask

  // Four-backplane view: the active backplane is the one against the frame polarity
  task grab(input [1:0] row);
    integer t;
    reg inv;
    begin
      t = 0;
      @(negedge clock);
      inv = (bp & (bp - 4'h1)) != 4'h0;
      while (bp[row] == inv && t < 100)
      begin
        @(negedge clock);
        inv = (bp & (bp - 4'h1)) != 4'h0;
        t = t + 1;
      end
      r = seg ^ {80{inv}};
    end
  endtask

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (byte_done)
      n_done <= n_done + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      close_out;
    end
  end

  initial
  begin
    rs = xs(rs);
    pins = rs[2:0];
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    put(1, {`LCDR_OP_CHIP, pins}, 1);
    chk(sub, pins);
    for (i = 0; i < 4; i = i + 1)
    begin
      put(1, {`LCDR_OP_MODE, 2'h0, i[1:0]}, 1);
      chk(mode, i[1:0]);
      rs = xs(rs);
      p = {1'b0, rs[5:0]};
      put(1, {1'b0, p}, 1);
      chk(ptr, p);
      put(0, rs[15:8], 1);
      chk(ptr, p + step(i[1:0]));
      chk(byte_ack, 1'b1);
    end
    put(1, {`LCDR_OP_MODE, 4'h0}, 1);
    put(1, 8'h4F, 1);
    put(0, rs[23:16], 1);
    q = pins + 3'h1;
    chk(ptr, 7'h01);
    chk(sub, q);
    chk(byte_ack, 1'b1);
    put(0, rs[31:24], 1);
    chk(ptr, 7'h03);
    chk(byte_ack, 1'b0);
    put(1, {`LCDR_OP_CHIP, pins}, 1);
    put(1, {`LCDR_OP_MODE, 2'h0, `LCDR_MODE_STATIC}, 1);
    put(1, 8'h00, 1);
    rs = xs(rs);
    b = rs[7:0];
    b2 = rs[15:8];
    put(0, b, 1);
    put(1, {`LCDR_OP_BANK, 2'h2}, 1);
    put(1, 8'h00, 1);
    put(0, b2, 1);
    look;
    chk(r[7:0], rev(b));
    put(1, {`LCDR_OP_BANK, 2'h3}, 1);
    put(1, {`LCDR_OP_CHIP, ~pins}, 1);
    put(1, 8'h00, 1);
    put(0, ~b2, 1);
    look;
    chk(r[7:0], rev(b2));
    put(1, {`LCDR_OP_CHIP, pins}, 1);
    put(1, {`LCDR_OP_BANK, 2'h0}, 1);
    put(1, 8'h08, 1);
    put(0, b2, 0);
    put(0, b, 1);
    chk(ptr, 7'h18);
    look;
    chk(r[23:0], {rev(b), rev(b2), rev(b)});
    put(1, {`LCDR_OP_MODE, 4'h0}, 1);
    put(1, 8'h20, 1);
    for (i = 0; i < 4; i = i + 1)
      put(0, 8'hFF, 1);
    put(0, 8'h1E, 1);
    put(1, {`LCDR_OP_BANK, 2'h3}, 1);
    rs = xs(rs);
    b = rs[7:0];
    b2 = rs[15:8];
    b3 = rs[23:16];
    put(1, {`LCDR_OP_MODE, 2'h0, `LCDR_MODE_TWO}, 1);
    put(1, 8'h20, 1);
    put(0, b, 1);
    put(1, {`LCDR_OP_MODE, 2'h0, `LCDR_MODE_THREE}, 1);
    put(1, 8'h24, 1);
    put(0, b2, 1);
    put(1, 8'h26, 1);
    put(0, b3, 1);
    chk(ptr, 7'h29);
    put(1, {`LCDR_OP_MODE, 4'h0}, 1);
    grab(2'h0);
    chk(r[41:32], {1'b1, b3[1], b3[4], b3[7], b2[4], b2[7], b[1], b[3], b[5], b[7]});
    grab(2'h1);
    chk(r[41:32], {1'b1, b3[0], b3[3], b3[6], b2[3], b2[6], b[0], b[2], b[4], b[6]});
    grab(2'h2);
    chk(r[41:32], {1'b1, 1'b0, b3[2], b3[5], b2[2], b2[5], 4'hF});
    grab(2'h3);
    chk(r[41:32], 10'h1FF);
    close_out;
  end
endmodule
